// ===== inc/xms_pkg.sv
// constants and types for the external memory strobe logic
// How it works
// - each space select rests high and goes low only while an access to its own space runs.
// - all strobe, direction and enable outputs float only when the disable pin is low, test reset is low and emulator pin zero is high.
// - the direction qualifier stays high (read) except during an external write, when it is low.
// - the inverted direction output is the complement of the qualifier, high only during a write.
// - read enable is asserted on every external read of program, data or I/O space.
// - the data bus is driven from the moment write enable falls.
// - write enable is asserted on every external write of program, data or I/O space.
// - the bus-cycle strobe rests high and goes low to mark an external bus cycle.
// - the bus-cycle strobe is asserted for every off-chip read or write in all three spaces.
// - the inverted direction pin doubles as a port bit, and that port bit is an input after reset.
// - a device that is not ready holds ready low; the access waits one cycle and samples ready again.
// - ready is sampled only when at least one wait state is programmed.
package xms_pkg;

    // ------------------------------------------------------------
    // address spaces and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        XMS_SPACE_PROG = 2'h0,
        XMS_SPACE_DATA = 2'h1,
        XMS_SPACE_IO   = 2'h2
    } xms_space_e;

    typedef enum logic [2:0] {
        XMS_IDLE   = 3'h1,
        XMS_ACCESS = 3'h2,
        XMS_WAIT   = 3'h4
    } xms_state_e;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int XMS_DATA_W = 16;
    localparam int XMS_WS_W = 3;
    localparam logic [XMS_WS_W-1:0] XMS_WS_RESET = 3'h0;
    localparam logic XMS_GPIO_DIR_RESET = 1'b0;
    localparam int XMS_SYNC_STAGES = 2;

endpackage

// ===== rtl/xms_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module xms_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== rtl/xms_strobe_ctrl.sv
// external memory interface strobe sequencer and pin drivers
`timescale 1ns/1ps
module xms_strobe_ctrl
    import xms_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // core access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire xms_pkg::xms_space_e req_space,
    input wire logic [XMS_DATA_W-1:0] req_wdata,
    input wire logic [XMS_WS_W-1:0] wait_states,
    output logic rsp_valid,
    output logic [XMS_DATA_W-1:0] rsp_rdata,
    // general-purpose use of the shared pin
    input wire logic port_c_bit_zero_mode_gpio,
    input wire logic port_c_bit_zero_dir_wr,
    input wire logic port_c_bit_zero_dir_val,
    input wire logic port_c_bit_zero_out_val,
    output logic port_c_bit_zero_in,
    // test pins
    input wire logic output_disable_test_pin,
    input wire logic test_reset,
    input wire logic emulator_pin_zero,
    // external bus strobes
    output logic program_space_select_n,
    output logic data_space_select_n,
    output logic io_space_select_n,
    output logic read_write_n,
    output logic read_enable_n,
    output logic write_enable_n,
    output logic bus_cycle_strobe_n,
    output logic strobe_oe,
    // shared pin: inverted direction or port bit
    input wire logic port_c_bit_zero_pin_in,
    output logic port_c_bit_zero_pin_out,
    output logic port_c_bit_zero_pin_oe,
    // data bus and ready
    input wire logic ready,
    input wire logic [XMS_DATA_W-1:0] data_in,
    output logic [XMS_DATA_W-1:0] data_out,
    output logic data_oe
);
    import xms_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic ready_s;
    logic off_s;
    logic trst_s;
    logic emulator_pin_zero_s;
    logic pc0_s;

    xms_sync #(.WIDTH(4)) u_sync_ctl (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({ready, output_disable_test_pin, test_reset, emulator_pin_zero}),
        .sync_out(pins_s)
    );
    xms_sync #(.WIDTH(1)) u_sync_pc0 (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(port_c_bit_zero_pin_in),
        .sync_out(pc0_s)
    );

    assign ready_s = pins_s[3];
    assign off_s = pins_s[2];
    assign trst_s = pins_s[1];
    assign emulator_pin_zero_s = pins_s[0];

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    xms_state_e state_q;
    logic [XMS_WS_W-1:0] ws_cnt_q;
    logic write_q;
    xms_space_e space_q;
    logic [XMS_DATA_W-1:0] wdata_q;
    logic done;
    logic wait_prev_q;

    // ready is only looked at once the programmed wait states have run out
    assign done = (state_q == XMS_ACCESS && wait_states == XMS_WS_RESET)
        || (state_q == XMS_WAIT && ws_cnt_q == XMS_WS_RESET
            && wait_prev_q && ready_s);

    assign req_ready = (state_q == XMS_IDLE);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= XMS_IDLE;
            ws_cnt_q <= XMS_WS_RESET;
        end else begin
            unique case (state_q)
                XMS_IDLE: begin
                    if (req_valid) begin
                        state_q <= XMS_ACCESS;
                    end
                end
                XMS_ACCESS: begin
                    if (done) begin
                        state_q <= XMS_IDLE;
                    end else begin
                        state_q <= XMS_WAIT;
                        ws_cnt_q <= wait_states - 3'h1;
                    end
                end
                XMS_WAIT: begin
                    if (ws_cnt_q != XMS_WS_RESET) begin
                        ws_cnt_q <= ws_cnt_q - 3'h1;
                    end else if (done) begin
                        state_q <= XMS_IDLE;
                    end
                    // not ready: stay one more cycle and sample again
                end
            endcase
        end
    end

    // synchronised ready lags the pin by two edges; with one wait state it would
    // still show the idle pull-up, so it is trusted only after a full wait cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_prev_q <= 1'b0;
        end else begin
            wait_prev_q <= (state_q == XMS_WAIT);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            write_q <= 1'b0;
            space_q <= XMS_SPACE_PROG;
            wdata_q <= '0;
        end else if (state_q == XMS_IDLE && req_valid) begin
            write_q <= req_write;
            space_q <= req_space;
            wdata_q <= req_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= done;
            if (done && !write_q) begin
                rsp_rdata <= data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // strobes, registered so the pins never glitch
    // ------------------------------------------------------------
    logic active_d;
    assign active_d = (state_q == XMS_IDLE) ? req_valid : !done;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            program_space_select_n <= 1'b1;
            data_space_select_n <= 1'b1;
            io_space_select_n <= 1'b1;
            read_write_n <= 1'b1;
            read_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            bus_cycle_strobe_n <= 1'b1;
            data_oe <= 1'b0;
            data_out <= '0;
        end else begin
            // one space decoded from a single captured code keeps the selects exclusive
            program_space_select_n <= !(active_d && space_q_n() == XMS_SPACE_PROG);
            data_space_select_n <= !(active_d && space_q_n() == XMS_SPACE_DATA);
            io_space_select_n <= !(active_d && space_q_n() == XMS_SPACE_IO);
            read_write_n <= !(active_d && write_n_d());
            read_enable_n <= !(active_d && !write_n_d());
            write_enable_n <= !(active_d && write_n_d());
            bus_cycle_strobe_n <= !active_d;
            data_oe <= active_d && write_n_d();
            data_out <= (state_q == XMS_IDLE) ? req_wdata : wdata_q;
        end
    end

    // request fields for the cycle being set up, from the port when idle
    function automatic xms_space_e space_q_n();
        return (state_q == XMS_IDLE) ? req_space : space_q;
    endfunction

    function automatic logic write_n_d();
        return (state_q == XMS_IDLE) ? req_write : write_q;
    endfunction

    // ------------------------------------------------------------
    // test float and shared pin
    // ------------------------------------------------------------
    logic float_all;
    assign float_all = !off_s && !trst_s && emulator_pin_zero_s;
    assign strobe_oe = !float_all;

    logic gpio_mode_q;
    logic gpio_dir_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gpio_mode_q <= 1'b1;
            gpio_dir_q <= XMS_GPIO_DIR_RESET;
        end else begin
            gpio_mode_q <= port_c_bit_zero_mode_gpio;
            if (port_c_bit_zero_dir_wr) begin
                gpio_dir_q <= port_c_bit_zero_dir_val;
            end
        end
    end

    always_comb begin
        if (gpio_mode_q) begin
            port_c_bit_zero_pin_out = port_c_bit_zero_out_val;
            port_c_bit_zero_pin_oe = gpio_dir_q && !float_all;
        end else begin
            port_c_bit_zero_pin_out = !read_write_n;
            port_c_bit_zero_pin_oe = !float_all;
        end
    end

    assign port_c_bit_zero_in = pc0_s;
endmodule

// ===== bench/xms_strobe_ctrl_assertions.sv
// concurrent checks on the strobe sequencer pins
`timescale 1ns/1ps
module xms_strobe_ctrl_assertions
    import xms_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire xms_pkg::xms_space_e req_space,
    input wire logic [XMS_WS_W-1:0] wait_states,
    input wire logic rsp_valid,
    // test pins
    input wire logic output_disable_test_pin,
    input wire logic test_reset,
    input wire logic emulator_pin_zero,
    // bus pins
    input wire logic program_space_select_n,
    input wire logic data_space_select_n,
    input wire logic io_space_select_n,
    input wire logic read_write_n,
    input wire logic read_enable_n,
    input wire logic write_enable_n,
    input wire logic bus_cycle_strobe_n,
    input wire logic strobe_oe,
    input wire logic data_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic take = req_valid && req_ready;
    wire logic off = !output_disable_test_pin && !test_reset && emulator_pin_zero;
    wire logic [2:0] sel_n = {io_space_select_n, data_space_select_n, program_space_select_n};
    // ----
    // sequences
    // ----
    sequence s_fast;
        ##1 !bus_cycle_strobe_n ##1 (rsp_valid && bus_cycle_strobe_n);
    endsequence
    sel_single_a: assert property ($onehot0(~sel_n))
        else $error("two space selects low");
    space_select_a: assert property (take |=> sel_n == ~(3'h1 << $past(req_space)))
        else $error("wrong space select");
    read_strobe_a: assert property (take && !req_write |=> !read_enable_n && write_enable_n && read_write_n)
        else $error("read strobes wrong");
    write_strobe_a: assert property (take && req_write |=> !write_enable_n && !read_write_n && read_enable_n)
        else $error("write strobes wrong");
    fast_answer_a: assert property (take && wait_states == 3'h0 |-> s_fast)
        else $error("zero wait access timing wrong");
    idle_strobes_a: assert property (req_ready |-> bus_cycle_strobe_n && read_enable_n && write_enable_n)
        else $error("strobe low while idle");
    dir_write_a: assert property (!read_write_n |-> !write_enable_n)
        else $error("direction low outside write");
    write_data_a: assert property ($fell(write_enable_n) |-> data_oe)
        else $error("data bus not driven at write");
    float_on_a: assert property (off [*4] |-> !strobe_oe)
        else $error("strobes not floated");
    float_off_a: assert property (!off [*4] |-> strobe_oe)
        else $error("strobes floated wrongly");
endmodule

bind xms_strobe_ctrl xms_strobe_ctrl_assertions i_xms_strobe_ctrl_assertions (.*);

// ===== bench/xms_ext_mem_model.sv
// behavioural external word memory with a stretching ready line
`timescale 1ns/1ps
module xms_ext_mem_model (
    // clock
    input wire logic core_clk,
    // strobes, ordered io, data, program
    input wire logic [2:0] sel_n,
    input wire logic rd_n,
    input wire logic we_n,
    input wire logic [15:0] wdata,
    // cycles to hold ready low, 0 = prompt
    input wire logic [3:0] stall,
    // answer
    output logic ready,
    output logic [15:0] rdata
);
    logic [15:0] mem [3];
    logic [15:0] last_q = 16'h0000;
    logic [3:0] cnt_q = 4'h0;
    wire logic [1:0] idx = sel_n[0] ? (sel_n[1] ? 2'h2 : 2'h1) : 2'h0;
    always @(posedge core_clk) begin
        cnt_q <= &sel_n ? 4'h0 : cnt_q + 4'h1;
        if (!we_n)
            mem[idx] <= wdata;
        if (!rd_n)
            last_q <= mem[idx];
    end
    // pulled up between cycles, low while the access is stretched
    assign ready = &sel_n || cnt_q >= stall;
    // a released bus shows the inverse of the last word so stale data never matches
    assign rdata = !rd_n ? mem[idx] : ~last_q;
endmodule

// ===== bench/tb_external_memory_strobe_logic.sv
// self-checking testbench for the external memory strobe logic
`timescale 1ns/1ps
module tb_external_memory_strobe_logic;
    import xms_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    xms_space_e req_space = XMS_SPACE_PROG;
    logic [XMS_DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, data_in, data_out;
    logic [XMS_WS_W-1:0] wait_states = 3'h0;
    logic port_c_bit_zero_mode_gpio = 1'b1, port_c_bit_zero_dir_wr = 1'b0;
    logic port_c_bit_zero_dir_val = 1'b0, port_c_bit_zero_out_val = 1'b0;
    logic output_disable_test_pin = 1'b1, test_reset = 1'b0, emulator_pin_zero = 1'b0;
    logic req_ready, rsp_valid, port_c_bit_zero_in, program_space_select_n;
    logic data_space_select_n, io_space_select_n, read_write_n, read_enable_n;
    logic write_enable_n, bus_cycle_strobe_n, strobe_oe, ready, data_oe;
    logic port_c_bit_zero_pin_out, port_c_bit_zero_pin_oe;
    wire logic port_c_bit_zero_pin_in = port_c_bit_zero_pin_oe ? port_c_bit_zero_pin_out : 1'b1;
    logic [3:0] stall = 4'h0;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n;
    always #2.5 core_clk = ~core_clk;
    xms_strobe_ctrl i_xms_strobe_ctrl (.*);
    xms_ext_mem_model i_xms_ext_mem_model (.core_clk(core_clk), .sel_n({io_space_select_n,
        data_space_select_n, program_space_select_n}), .rd_n(read_enable_n), .we_n(write_enable_n),
        .wdata(data_oe ? data_out : ~data_out), .stall(stall), .ready(ready), .rdata(data_in));
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered just after an edge; returns just after the edge that shows the answer
    task automatic acc(input logic w, input xms_space_e s, input logic [15:0] d, output int k);
        req_valid = 1'b1;
        req_write = w;
        req_space = s;
        req_wdata = d;
        @(posedge core_clk) #1;
        req_valid = 1'b0;
        chk({io_space_select_n, data_space_select_n, program_space_select_n}, 3'h7 ^ (3'h1 << s));
        chk({read_enable_n, write_enable_n, read_write_n, bus_cycle_strobe_n}, {w, !w, !w, 1'b0});
        chk({port_c_bit_zero_pin_out, port_c_bit_zero_pin_oe, data_oe}, {w, 1'b1, w});
        if (w)
            chk(data_out, d);
        k = 0;
        while (!rsp_valid && k < 40) begin
            @(posedge core_clk) #1;
            k++;
            if (!rsp_valid)
                chk(bus_cycle_strobe_n, 1'b0);
        end
        chk(bus_cycle_strobe_n, 1'b1);
        if (!w)
            chk(rsp_rdata, d);
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        chk({program_space_select_n, data_space_select_n, io_space_select_n, read_write_n}, 4'hF);
        chk({bus_cycle_strobe_n, port_c_bit_zero_pin_oe, data_oe}, 3'h4);
    endtask
    // back-to-back write then read in every space
    task automatic t_spaces;
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, xms_space_e'(i), 16'hC3A5 ^ 16'(i), n);
            acc(1'b0, xms_space_e'(i), 16'hC3A5 ^ 16'(i), n);
        end
    endtask
    task automatic t_wait;
        stall = 4'h4;
        acc(1'b0, XMS_SPACE_DATA, 16'hC3A4, n);
        chk(16'(n), 16'h0001);
        wait_states = 3'h2;
        acc(1'b0, XMS_SPACE_DATA, 16'hC3A4, n);
        chk(16'(n > 4), 16'h0001);
        // one wait state: a stale idle ready must not end the access early
        wait_states = 3'h1;
        acc(1'b0, XMS_SPACE_DATA, 16'hC3A4, n);
        chk(16'(n > 4), 16'h0001);
        stall = 4'h0;
        acc(1'b1, XMS_SPACE_IO, 16'h0000, n);
        chk(16'(n >= 3), 16'h0001);
    endtask
    task automatic t_float;
        logic [2:0] pat [4] = '{3'b011, 3'b001, 3'b000, 3'b101};
        for (int i = 0; i < 4; i++) begin
            {output_disable_test_pin, test_reset, emulator_pin_zero} = pat[i];
            repeat (4) @(posedge core_clk);
            #1 chk({strobe_oe, port_c_bit_zero_pin_oe}, {2{pat[i] != 3'b001}});
        end
    endtask
    // shared pin as a port bit: input after reset, then driven out and read back
    task automatic t_gpio;
        port_c_bit_zero_mode_gpio = 1'b1;
        port_c_bit_zero_out_val = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk({port_c_bit_zero_pin_oe, port_c_bit_zero_in}, 2'h1);
        port_c_bit_zero_dir_wr = 1'b1;
        port_c_bit_zero_dir_val = 1'b1;
        @(posedge core_clk) #1;
        port_c_bit_zero_dir_wr = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk({port_c_bit_zero_pin_oe, port_c_bit_zero_pin_out, port_c_bit_zero_in}, 3'h4);
        port_c_bit_zero_out_val = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk(port_c_bit_zero_in, 1'b1);
    endtask
    // ----
    // main sequence and hang guard
    // ----
    initial begin
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1'b1;
        t_reset;
        port_c_bit_zero_mode_gpio = 1'b0;
        @(posedge core_clk) #1;
        t_spaces;
        t_wait;
        t_float;
        t_gpio;
        test_done;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done;
        end
    end
endmodule
